// file: inc/txq_consts.vh
// Constants for the transmit descriptor queue engine.
// Assumes 16-bit descriptor words in shared memory, big-endian bytes.
// Function
// - Low fifteen length bits count buffer bytes
// - Indication word written only for receive
// - Rx last flag set on final buffer
// - Unused byte count written into indication
// - Buffers up to 32K-1, one per descriptor
// - Store to 64K, flag noise above 8K
// - No transmit length check against 8K
// - Header bytes sent without validation
// - Four transmit queues, one per class
// - Frame done set after transmission
// - Drained flag inverts sampled link bit
// - Done and drained in one write
// - Start command loads queue head pointer
// - Linked frames sent without start
// - Queue end flag bit 3 set
// - Confirm word, negative, then done interrupt
// - Underrun flags, retry up to limit
// - Follow buffers until last buffer flag
`ifndef TXQ_CONSTS_VH
`define TXQ_CONSTS_VH

// Register indices
`define TXQ_REG_CMD       4'h0
`define TXQ_REG_HEAD_LO   4'h1
`define TXQ_REG_HEAD_HI   4'h2
`define TXQ_REG_INT_STAT  4'h3
`define TXQ_REG_RETRY     4'h4
`define TXQ_REG_STATUS    4'h5
`define TXQ_CMD_START     2
`define TXQ_RETRY_RESET   8'h00
// Interrupt status word 0 bits
`define TXQ_IS_QEND       3
`define TXQ_IS_DONE       4
`define TXQ_IS_UNDERRUN   5
`define TXQ_IS_NOISE      6
// Frame descriptor offsets
`define TXQ_FD_CONF       32'h0000_0000
`define TXQ_FD_CTRL       32'h0000_0004
`define TXQ_FD_NEXT       32'h0000_0006
`define TXQ_FD_FIRST_BD   32'h0000_000C
`define TXQ_FD_LEN        32'h0000_0010
// Buffer descriptor offsets
`define TXQ_BD_DATA       32'h0000_0002
`define TXQ_BD_RX_IND     32'h0000_000A
`define TXQ_BD_NEXT       32'h0000_000E
// Field positions
`define TXQ_NLV_BIT       15
`define TXQ_LAST_BIT      15
`define TXQ_CF_DONE       15
`define TXQ_CF_NEG        14
`define TXQ_CF_DRAINED    13
`define TXQ_CF_UNDERRUN   12
`define TXQ_CF_TOO_LONG   11
// Receive noise threshold, 8K bytes
`define TXQ_NOISE_LIMIT   17'h0_2000

`endif

// file: rtl/txq_engine.v
// Transmit descriptor queue engine with receive indication writer.
// Assumes a single-clock memory master port; ack is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
`include "txq_consts.vh"
module txq_engine (
	// Clock and reset
	input  wire        clk_in,
	input  wire        reset_in,
	// Register port
	input  wire [3:0]  reg_addr_in,
	input  wire [15:0] reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output reg  [15:0] reg_rdata_out,
	// Memory master
	output reg         mem_req_out,
	output reg         mem_we_out,
	output reg  [31:0] mem_addr_out,
	output reg  [15:0] mem_wdata_out,
	input  wire        mem_ack_in,
	input  wire [15:0] mem_rdata_in,
	// Transmit byte stream
	output wire        tx_valid_out,
	output reg  [7:0]  tx_data_out,
	input  wire        tx_ready_in,
	output reg  [1:0]  tx_class_out,
	output reg         tx_end_out,
	input  wire        tx_status_in,
	input  wire        tx_fail_in,
	input  wire        tx_underrun_in,
	// Receive indication request
	input  wire        rx_ind_req_in,
	input  wire [31:0] rx_bd_addr_in,
	input  wire [14:0] rx_buf_len_in,
	input  wire [14:0] rx_filled_in,
	input  wire        rx_last_in,
	input  wire [16:0] rx_frame_len_in,
	output wire        rx_busy_out
);
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_RD   = 4'h1;
	localparam [3:0] S_DATA = 4'h2;
	localparam [3:0] S_SEND = 4'h3;
	localparam [3:0] S_WAIT = 4'h4;
	localparam [3:0] S_NLV  = 4'h5;
	localparam [3:0] S_CONF = 4'h6;
	localparam [3:0] S_RX   = 4'h7;

	reg  [3:0]  state;
	reg  [2:0]  step;
	reg         is_bd;
	reg  [31:0] head [0:3];
	reg  [3:0]  active;
	reg  [15:0] head_lo;
	reg  [15:0] head_hi;
	reg  [15:0] int_stat;
	reg  [7:0]  retry_limit;
	reg  [7:0]  retries;
	reg  [31:0] fd_ptr;
	reg  [31:0] bd_ptr;
	reg  [31:0] first_bd;
	reg  [31:0] next_fd;
	reg  [31:0] next_bd;
	reg  [31:0] data_ptr;
	reg  [14:0] data_off;
	reg  [14:0] buf_len;
	reg  [14:0] idx;
	reg  [15:0] frame_len;
	reg  [15:0] frame_sum;
	reg         link_valid;
	reg         last_buf;
	reg         fail;
	reg         underrun;
	reg         rx_pend;
	reg  [31:0] rx_addr;
	wire [15:0] rx_word;
	wire        rx_noise;
	reg  [1:0]  pick;
	reg         any;
	reg         req_comb;
	reg         we_comb;
	reg  [31:0] addr_comb;
	reg  [15:0] wdata_comb;
	integer     i;

	// Byte offset of the word read at each descriptor fetch step
	function [31:0] rd_off;
		input       bd;
		input [2:0] s;
		begin
			case (s)
				3'd0:    rd_off = bd ? `TXQ_BD_DATA : `TXQ_FD_CTRL;
				3'd1:    rd_off = bd ? `TXQ_BD_DATA + 32'h0000_0002 : `TXQ_FD_NEXT;
				3'd2:    rd_off = bd ? `TXQ_BD_DATA + 32'h0000_0004 : `TXQ_FD_NEXT + 32'h0000_0002;
				3'd3:    rd_off = bd ? `TXQ_BD_DATA + 32'h0000_0006 : `TXQ_FD_FIRST_BD;
				3'd4:    rd_off = bd ? `TXQ_BD_NEXT : `TXQ_FD_FIRST_BD + 32'h0000_0002;
				default: rd_off = bd ? `TXQ_BD_NEXT + 32'h0000_0002 : `TXQ_FD_LEN;
			endcase
		end
	endfunction

	txq_rx_ind u_rx_ind (
		.clk_in       (clk_in),
		.reset_in     (reset_in),
		.req_in       (rx_ind_req_in && !rx_pend),
		.buf_len_in   (rx_buf_len_in),
		.filled_in    (rx_filled_in),
		.last_in      (rx_last_in),
		.frame_len_in (rx_frame_len_in),
		.ind_word_out (rx_word),
		.noise_out    (rx_noise)
	);

	assign tx_valid_out = (state == S_SEND);
	assign rx_busy_out  = rx_pend;

	// Lowest class number wins among active queues
	always @* begin
		pick = 2'd0;
		any  = 1'b0;
		for (i = 3; i >= 0; i = i - 1) begin
			if (active[i]) begin
				pick = i[1:0];
				any  = 1'b1;
			end
		end
	end

	wire [31:0] byte_addr = data_ptr + {17'h0_0000, data_off} + {17'h0_0000, idx};
	wire        too_long  = frame_sum > frame_len;
	wire        underrun_now = tx_status_in && tx_underrun_in;
	wire        retry_ok  = underrun_now && (retries < retry_limit);

	// Memory request for the current state
	always @* begin
		req_comb   = 1'b0;
		we_comb    = 1'b0;
		addr_comb  = 32'h0000_0000;
		wdata_comb = 16'h0000;
		case (state)
			S_RD: begin
				req_comb  = 1'b1;
				addr_comb = (is_bd ? bd_ptr : fd_ptr) + rd_off(is_bd, step);
			end
			S_DATA: begin
				req_comb  = 1'b1;
				addr_comb = {byte_addr[31:1], 1'b0};
			end
			S_NLV: begin
				req_comb  = 1'b1;
				addr_comb = fd_ptr + `TXQ_FD_CTRL;
			end
			S_CONF: begin
				req_comb  = 1'b1;
				we_comb   = 1'b1;
				addr_comb = fd_ptr + `TXQ_FD_CONF;
				wdata_comb[`TXQ_CF_DONE]     = 1'b1;
				wdata_comb[`TXQ_CF_NEG]      = fail || too_long;
				wdata_comb[`TXQ_CF_DRAINED]  = !link_valid;
				wdata_comb[`TXQ_CF_UNDERRUN] = underrun;
				wdata_comb[`TXQ_CF_TOO_LONG] = too_long;
			end
			S_RX: begin
				req_comb   = 1'b1;
				we_comb    = 1'b1;
				addr_comb  = rx_addr + `TXQ_BD_RX_IND;
				wdata_comb = rx_word;
			end
			default: begin
				req_comb = 1'b0;
			end
		endcase
	end

	// Registered memory outputs; one idle cycle after each ack
	always @(posedge clk_in) begin
		if (reset_in) begin
			mem_req_out   <= 1'b0;
			mem_we_out    <= 1'b0;
			mem_addr_out  <= 32'h0000_0000;
			mem_wdata_out <= 16'h0000;
		end else begin
			mem_req_out   <= req_comb && !mem_ack_in;
			mem_we_out    <= we_comb;
			mem_addr_out  <= addr_comb;
			mem_wdata_out <= wdata_comb;
		end
	end

	// Register read port
	always @(posedge clk_in) begin
		if (reset_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`TXQ_REG_HEAD_LO:  reg_rdata_out <= head_lo;
				`TXQ_REG_HEAD_HI:  reg_rdata_out <= head_hi;
				`TXQ_REG_INT_STAT: reg_rdata_out <= int_stat;
				`TXQ_REG_RETRY:    reg_rdata_out <= {8'h00, retry_limit};
				`TXQ_REG_STATUS:   reg_rdata_out <= {8'h00, state, active};
				default:           reg_rdata_out <= 16'h0000;
			endcase
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

	wire wr_stat = reg_wr_in && (reg_addr_in == `TXQ_REG_INT_STAT);
	wire conf_done = (state == S_CONF) && mem_ack_in;

	// Register writes and interrupt status; set wins over clear
	always @(posedge clk_in) begin
		if (reset_in) begin
			head_lo     <= 16'h0000;
			head_hi     <= 16'h0000;
			retry_limit <= `TXQ_RETRY_RESET;
			int_stat    <= 16'h0000;
		end else begin
			if (reg_wr_in && reg_addr_in == `TXQ_REG_HEAD_LO) head_lo <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == `TXQ_REG_HEAD_HI) head_hi <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == `TXQ_REG_RETRY) retry_limit <= reg_wdata_in[7:0];
			int_stat <= (int_stat & ~(wr_stat ? reg_wdata_in : 16'h0000))
				| ({15'h0000, conf_done && !link_valid} << `TXQ_IS_QEND)
				| ({15'h0000, conf_done} << `TXQ_IS_DONE)
				| ({15'h0000, underrun_now && state == S_WAIT} << `TXQ_IS_UNDERRUN)
				| ({15'h0000, rx_noise} << `TXQ_IS_NOISE);
		end
	end

	// Receive indication pending write
	always @(posedge clk_in) begin
		if (reset_in) begin
			rx_pend <= 1'b0;
			rx_addr <= 32'h0000_0000;
		end else if (rx_ind_req_in && !rx_pend) begin
			rx_pend <= 1'b1;
			rx_addr <= rx_bd_addr_in;
		end else if (state == S_RX && mem_ack_in) begin
			rx_pend <= 1'b0;
		end
	end

	// Main sequencer
	always @(posedge clk_in) begin
		if (reset_in) begin
			state      <= S_IDLE;
			step       <= 3'd0;
			is_bd      <= 1'b0;
			active     <= 4'h0;
			retries    <= 8'h00;
			fd_ptr     <= 32'h0000_0000;
			bd_ptr     <= 32'h0000_0000;
			first_bd   <= 32'h0000_0000;
			next_fd    <= 32'h0000_0000;
			next_bd    <= 32'h0000_0000;
			data_ptr   <= 32'h0000_0000;
			data_off   <= 15'h0000;
			buf_len    <= 15'h0000;
			idx        <= 15'h0000;
			frame_len  <= 16'h0000;
			frame_sum  <= 16'h0000;
			link_valid <= 1'b0;
			last_buf   <= 1'b0;
			fail       <= 1'b0;
			underrun   <= 1'b0;
			tx_data_out  <= 8'h00;
			tx_class_out <= 2'd0;
			tx_end_out   <= 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				head[i] <= 32'h0000_0000;
			end
		end else begin
			tx_end_out <= 1'b0;
			if (reg_wr_in && reg_addr_in == `TXQ_REG_CMD && reg_wdata_in[`TXQ_CMD_START]) begin
				head[reg_wdata_in[1:0]]   <= {head_hi, head_lo};
				active[reg_wdata_in[1:0]] <= 1'b1;
			end
			case (state)
				S_IDLE: begin
					if (rx_pend) begin
						state <= S_RX;
					end else if (any) begin
						tx_class_out <= pick;
						fd_ptr       <= head[pick];
						is_bd        <= 1'b0;
						step         <= 3'd0;
						retries      <= 8'h00;
						underrun     <= 1'b0;
						state        <= S_RD;
					end
				end
				S_RD: begin
					if (mem_ack_in) begin
						if (!is_bd) begin
							case (step)
								3'd0: link_valid <= mem_rdata_in[`TXQ_NLV_BIT];
								3'd1: next_fd[31:16] <= mem_rdata_in;
								3'd2: next_fd[15:0] <= mem_rdata_in;
								3'd3: first_bd[31:16] <= mem_rdata_in;
								3'd4: first_bd[15:0] <= mem_rdata_in;
								default: frame_len <= mem_rdata_in;
							endcase
						end else begin
							case (step)
								3'd0: data_ptr[31:16] <= mem_rdata_in;
								3'd1: data_ptr[15:0] <= mem_rdata_in;
								3'd2: begin
									last_buf <= mem_rdata_in[`TXQ_LAST_BIT];
									data_off <= mem_rdata_in[14:0];
								end
								3'd3: buf_len <= mem_rdata_in[14:0];
								3'd4: next_bd[31:16] <= mem_rdata_in;
								default: next_bd[15:0] <= mem_rdata_in;
							endcase
						end
						if (step != 3'd5) begin
							step <= step + 3'd1;
						end else if (!is_bd) begin
							is_bd     <= 1'b1;
							step      <= 3'd0;
							bd_ptr    <= {first_bd[31:16], first_bd[15:0]};
							frame_sum <= 16'h0000;
							fail      <= 1'b0;
						end else begin
							idx   <= 15'h0000;
							state <= (buf_len == 15'h0000) ? S_WAIT : S_DATA;
						end
					end
				end
				S_DATA: begin
					if (mem_ack_in) begin
						// Header and data bytes pass unchecked
						tx_data_out <= byte_addr[0] ? mem_rdata_in[7:0] : mem_rdata_in[15:8];
						state       <= S_SEND;
					end
				end
				S_SEND: begin
					if (tx_ready_in) begin
						// End pulse with the last byte of the last buffer
						tx_end_out <= last_buf && (idx + 15'h0001 == buf_len);
						frame_sum <= frame_sum + 16'h0001;
						if (idx + 15'h0001 != buf_len) begin
							idx   <= idx + 15'h0001;
							state <= S_DATA;
						end else begin
							state <= S_WAIT;
						end
					end
				end
				S_WAIT: begin
					if (!last_buf) begin
						bd_ptr <= next_bd;
						step   <= 3'd0;
						state  <= S_RD;
					end else begin
						if (tx_status_in) begin
							fail <= tx_fail_in;
							if (tx_underrun_in) begin
								underrun <= 1'b1;
							end
							if (retry_ok) begin
								retries   <= retries + 8'h01;
								bd_ptr    <= first_bd;
								frame_sum <= 16'h0000;
								step      <= 3'd0;
								state     <= S_RD;
							end else begin
								state <= S_NLV;
							end
						end
					end
				end
				S_NLV: begin
					if (mem_ack_in) begin
						link_valid <= mem_rdata_in[`TXQ_NLV_BIT];
						state      <= S_CONF;
					end
				end
				S_CONF: begin
					if (mem_ack_in) begin
						if (link_valid) begin
							head[tx_class_out] <= next_fd;
						end else begin
							active[tx_class_out] <= 1'b0;
						end
						state <= S_IDLE;
					end
				end
				S_RX: begin
					if (mem_ack_in) begin
						state <= S_IDLE;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: rtl/txq_rx_ind.v
// Builds the receive indication word of a buffer descriptor.
// Assumes request fields are stable in the cycle the request is high.
`timescale 1ns/10ps
`default_nettype none
`include "txq_consts.vh"
module txq_rx_ind (
	// Clock and reset
	input  wire        clk_in,
	input  wire        reset_in,
	// Request
	input  wire        req_in,
	input  wire [14:0] buf_len_in,
	input  wire [14:0] filled_in,
	input  wire        last_in,
	input  wire [16:0] frame_len_in,
	// Result
	output reg  [15:0] ind_word_out,
	output reg         noise_out
);
	wire [14:0] unused = buf_len_in - filled_in;

	always @(posedge clk_in) begin
		if (reset_in) begin
			ind_word_out <= 16'h0000;
			noise_out    <= 1'b0;
		end else begin
			noise_out <= req_in && (frame_len_in > `TXQ_NOISE_LIMIT);
			if (req_in) begin
				ind_word_out <= {last_in, unused};
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the transmit queue engine.
// Assumes txq_mem_model as memory; the MAC side is driven here.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [3:0]  reg_addr_in = 4'h0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [15:0] reg_rdata_out;
	logic        mem_req_out;
	logic        mem_we_out;
	logic [31:0] mem_addr_out;
	logic [15:0] mem_wdata_out;
	logic        mem_ack_in;
	logic [15:0] mem_rdata_in;
	logic        tx_valid_out;
	logic [7:0]  tx_data_out;
	logic        tx_ready_in = 1'b0;
	logic [1:0]  tx_class_out;
	logic        tx_end_out;
	int          ends = 0;
	logic        tx_status_in = 1'b0;
	logic        tx_fail_in = 1'b0;
	logic        tx_underrun_in = 1'b0;
	logic        rx_ind_req_in = 1'b0;
	logic [31:0] rx_bd_addr_in = 32'h0000_0300;
	logic [14:0] rx_buf_len_in = 15'h0064;
	logic [14:0] rx_filled_in = 15'h0028;
	logic        rx_last_in = 1'b0;
	logic [16:0] rx_frame_len_in = 17'h0_2000;
	logic        rx_busy_out;
	logic [7:0]  got [$];
	logic [1:0]  cls;
	int          errors = 0;
	int          comparisons = 0;
	txq_engine dut (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out,
		.mem_ack_in, .mem_rdata_in, .tx_valid_out, .tx_data_out, .tx_ready_in,
		.tx_class_out, .tx_end_out, .tx_status_in, .tx_fail_in, .tx_underrun_in,
		.rx_ind_req_in, .rx_bd_addr_in, .rx_buf_len_in, .rx_filled_in, .rx_last_in,
		.rx_frame_len_in, .rx_busy_out);
	txq_mem_model m (.clk_in, .req_in(mem_req_out), .we_in(mem_we_out),
		.addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .ack_out(mem_ack_in),
		.rdata_out(mem_rdata_in));
	always #12.5 clk_in = ~clk_in;
	// MAC takes bytes every other cycle
	always @(posedge clk_in) begin
		tx_ready_in <= ~tx_ready_in;
		if (tx_end_out)
			ends++;
		if (tx_valid_out && tx_ready_in) begin
			got.push_back(tx_data_out);
			cls <= tx_class_out;
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		chk(reg_rdata_out, e);
	endtask
	task automatic put(input logic [31:0] a, input logic [15:0] v [9]);
		for (int i = 0; i < 9; i++)
			m.mem[a[10:1] + i] = v[i];
	endtask
	task automatic mkfd(input logic [31:0] a, nx, bd, input logic nlv, input logic [15:0] ln);
		put(a, '{16'h0000, 16'h0000, {nlv, 15'h0000}, nx[31:16], nx[15:0],
			16'h0000, bd[31:16], bd[15:0], ln});
	endtask
	task automatic start(input logic [15:0] fd, input logic [1:0] c);
		wr(4'h1, fd);
		wr(4'h2, 16'h0000);
		wr(4'h0, {14'h0001, c});
	endtask
	task automatic mac(input int n, input logic f, input logic u);
		for (int i = 0; i < 3000 && got.size() < n; i++)
			@(posedge clk_in);
		repeat (4) @(posedge clk_in);
		tx_status_in <= 1'b1;
		tx_fail_in <= f;
		tx_underrun_in <= u;
		@(posedge clk_in);
		tx_status_in <= 1'b0;
		tx_fail_in <= 1'b0;
		tx_underrun_in <= 1'b0;
	endtask
	task automatic conf(input logic [31:0] a, input logic [15:0] e);
		for (int i = 0; i < 3000 && m.mem[a[10:1]] === 16'h0000; i++)
			@(posedge clk_in);
		repeat (4) @(posedge clk_in);
		chk(m.mem[a[10:1]], e);
	endtask
	task automatic bytes(input logic [7:0] e [$]);
		chk(16'(got.size()), 16'(e.size()));
		foreach (e[i])
			chk({8'h00, got[i]}, {8'h00, e[i]});
		got = {};
	endtask
	task automatic conclude;
		if (errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_in);
		errors++;
		conclude;
	end
	initial begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		// Chain of two buffers, one single buffer shared later
		put(32'h0000_0200, '{16'h0000, 16'h0000, 16'h0400, 16'h0000, 16'h0003,
			16'h0000, 16'h0000, 16'h0000, 16'h0240});
		put(32'h0000_0240, '{16'h0000, 16'h0000, 16'h0480, 16'h8000, 16'h0002,
			16'h0000, 16'h0000, 16'h0000, 16'h0000});
		put(32'h0000_0280, '{16'h0000, 16'h0000, 16'h0480, 16'h8000, 16'h0002,
			16'h0000, 16'h0000, 16'h0000, 16'h0000});
		m.mem[10'h200] = 16'h1122;
		m.mem[10'h201] = 16'h3344;
		m.mem[10'h240] = 16'h5566;
		rd(4'hF, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			mkfd(32'h0000_0100, 32'h0000_0000, 32'h0000_0200, 1'b0, 16'h0005);
			start(16'h0100, c[1:0]);
			mac(5, 1'b0, 1'b0);
			conf(32'h0000_0100, 16'hA000);
			bytes('{8'h11, 8'h22, 8'h33, 8'h55, 8'h66});
			chk({14'h0000, cls}, c[15:0]);
			chk(16'(ends), 16'(c + 1));
			rd(4'h3, 16'h0018);
			wr(4'h3, 16'hFFFF);
		end
		// Linked pair, short length then failure
		mkfd(32'h0000_0140, 32'h0000_0180, 32'h0000_0280, 1'b1, 16'h0001);
		mkfd(32'h0000_0180, 32'h0000_0000, 32'h0000_0280, 1'b0, 16'h0002);
		start(16'h0140, 2'h2);
		mac(2, 1'b0, 1'b0);
		conf(32'h0000_0140, 16'hC800);
		mac(4, 1'b1, 1'b0);
		conf(32'h0000_0180, 16'hE000);
		bytes('{8'h55, 8'h66, 8'h55, 8'h66});
		// Late link on a drained queue needs a new start
		mkfd(32'h0000_01C0, 32'h0000_0000, 32'h0000_0280, 1'b0, 16'h0002);
		m.mem[10'h0C2] = 16'h8000;
		m.mem[10'h0C4] = 16'h01C0;
		repeat (150) @(posedge clk_in);
		chk(16'(got.size()), 16'h0000);
		chk(m.mem[10'h0E0], 16'h0000);
		wr(4'h3, 16'hFFFF);
		wr(4'h4, 16'h0001);
		start(16'h01C0, 2'h3);
		mac(2, 1'b0, 1'b1);
		mac(4, 1'b0, 1'b0);
		conf(32'h0000_01C0, 16'hB000);
		bytes('{8'h55, 8'h66, 8'h55, 8'h66});
		rd(4'h3, 16'h0038);
		wr(4'h3, 16'hFFFF);
		// Receive indication word, at and just above the noise limit
		for (int k = 0; k < 2; k++) begin
			m.mem[10'h185] = 16'hFFFF;
			@(posedge clk_in);
			rx_last_in <= k[0];
			rx_frame_len_in <= {16'h1000, k[0]};
			rx_ind_req_in <= 1'b1;
			@(posedge clk_in);
			rx_ind_req_in <= 1'b0;
			for (int i = 0; i < 500 && m.mem[10'h185] === 16'hFFFF; i++)
				@(posedge clk_in);
			repeat (4) @(posedge clk_in);
			chk(m.mem[10'h185], {k[0], 15'h003C});
			rd(4'h3, {9'h000, k[0], 6'h00});
			wr(4'h3, 16'hFFFF);
		end
		conclude;
	end
endmodule
bind txq_engine txq_engine_asserts chk_i (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in,
	.reg_wr_in, .reg_rd_in, .reg_rdata_out, .mem_req_out, .mem_we_out, .mem_addr_out,
	.mem_wdata_out, .mem_ack_in, .tx_valid_out, .tx_data_out, .tx_ready_in);
`default_nettype wire

// file: tb/txq_engine_asserts.sv
// Port checks for the transmit queue engine.
// Assumes binding onto txq_engine by port name.
`timescale 1ns/10ps
`default_nettype none
module txq_engine_asserts (
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic [3:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        mem_req_out,
	input wire logic        mem_we_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic [15:0] mem_wdata_out,
	input wire logic        mem_ack_in,
	input wire logic        tx_valid_out,
	input wire logic [7:0]  tx_data_out,
	input wire logic        tx_ready_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_req_holds: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
		&& $stable(mem_addr_out) && $stable(mem_we_out) && $stable(mem_wdata_out))
		else $error("memory request changed before ack");
	a_req_gap: assert property (mem_ack_in |=> !mem_req_out)
		else $error("request not dropped after ack");
	a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (reg_rd_in && (reg_addr_in == 4'h0
		|| reg_addr_in > 4'h5) |=> reg_rdata_out == 16'h0000)
		else $error("command or unmapped read not zero");
	a_byte_stands: assert property (tx_valid_out && !tx_ready_in
		|=> tx_valid_out && $stable(tx_data_out))
		else $error("byte withdrawn before taken");
	a_even_addr: assert property (mem_req_out |-> !mem_addr_out[0])
		else $error("odd memory address");
	a_reset_quiet: assert property ($fell(reset_in) |-> !mem_req_out && !tx_valid_out)
		else $error("activity right after reset");
	a_start_fetch: assert property (reg_wr_in && reg_addr_in == 4'h0
		&& reg_wdata_in[2] && !mem_req_out && !tx_valid_out |-> ##[1:6] mem_req_out)
		else $error("start gave no fetch");
endmodule
`default_nettype wire

// file: tb/txq_mem_model.sv
// Shared memory model answering the engine's bus master port.
// Assumes one request at a time, held until the ack pulse.
`timescale 1ns/10ps
`default_nettype none
module txq_mem_model (
	// Clock
	input  wire logic        clk_in,
	// Request from engine
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic [31:0] addr_in,
	input  wire logic [15:0] wdata_in,
	// Answer
	output var  logic        ack_out,
	output var  logic [15:0] rdata_out
);
	logic [15:0] mem [0:1023];
	logic [1:0]  cnt;
	logic [1:0]  lat;
	initial begin
		ack_out = 1'b0;
		rdata_out = 16'h0000;
		cnt = 2'h0;
		lat = 2'h0;
		foreach (mem[i])
			mem[i] = 16'h0000;
	end
	// Latency alternates between prompt and slow
	always @(posedge clk_in) begin
		if (ack_out || !req_in) begin
			ack_out <= 1'b0;
			cnt <= 2'h0;
			rdata_out <= ~rdata_out;
		end else if (cnt == lat) begin
			ack_out <= 1'b1;
			lat <= ~lat;
			if (we_in)
				mem[addr_in[10:1]] <= wdata_in;
			else
				rdata_out <= mem[addr_in[10:1]];
		end else begin
			cnt <= cnt + 2'h1;
			rdata_out <= ~rdata_out;
		end
	end
endmodule
`default_nettype wire
